/* File: rtl/ssmw_pkg.sv */
// Package: register map, status layout, commands and timing of the sequencer register bank
package ssmw_pkg;
	// Register pointer values as seen over the two-wire host link
	localparam logic [7:0] REG_RAIL_FIRST    = 8'h00;
	localparam logic [7:0] REG_RAIL_LAST     = 8'h0F;
	localparam logic [7:0] REG_ERRLOG_FIRST  = 8'h20;
	localparam logic [7:0] REG_ERRLOG_LAST   = 8'h25;
	localparam logic [7:0] REG_DEVICE_STATUS = 8'h26;
	localparam logic [7:0] REG_REVISION_INFO = 8'h27;
	localparam logic [7:0] REG_RAIL_MASK_HI  = 8'h28;
	localparam logic [7:0] REG_RAIL_MASK_LO  = 8'h29;
	localparam logic [7:0] REG_MEM_LOCK      = 8'h2E;
	localparam logic [7:0] REG_RESTART_CMD   = 8'h2F;
	localparam logic [7:0] REG_WIN_ADDR_LO   = 8'h30;
	localparam logic [7:0] REG_WIN_ADDR_HI   = 8'h31;
	localparam logic [7:0] REG_WIN_DATA_LO   = 8'h32;
	localparam logic [7:0] REG_WIN_DATA_HI   = 8'h33;

	// Status byte bit positions
	localparam int ST_BUS_FAULT  = 7;
	localparam int ST_RAIL_FAULT = 6;
	localparam int ST_LOG_PRES   = 5;
	localparam int ST_FW_FAULT   = 4;
	localparam int ST_CFG_INVAL  = 3;

	// Cause codes held in status bits 1:0
	localparam logic [1:0] CAUSE_NONE     = 2'h0;
	localparam logic [1:0] CAUSE_BAD_ADDR = 2'h1;
	localparam logic [1:0] CAUSE_RD_ERR   = 2'h2;
	localparam logic [1:0] CAUSE_WR_ERR   = 2'h3;

	// Byte-count limits per transaction; zero means not checked here
	localparam logic [1:0] LIM_FREE   = 2'h0;
	localparam logic [1:0] LIM_SINGLE = 2'h1;
	localparam logic [1:0] LIM_PAIR   = 2'h2;

	// Command and lock values
	localparam logic [7:0] CMD_RESTART  = 8'h00;
	localparam logic [7:0] CMD_SHUTDOWN = 8'hC0;
	localparam logic [7:0] LOCK_OPEN    = 8'h02;
	localparam logic [7:0] LOCK_CLOSED  = 8'h00;

	// Restart hold-off so the acknowledge can finish
	localparam int CLK_KHZ          = 40000;
	localparam int RESTART_DELAY_US = 50;
	localparam int RESTART_CYC      = (RESTART_DELAY_US * CLK_KHZ + 999) / 1000;
	localparam int RESTART_CNT_W    = 12;

	typedef enum logic [0:0] {
		SSMW_RS_IDLE,
		SSMW_RS_WAIT
	} ssmw_restart_state_t;
endpackage : ssmw_pkg

/* File: rtl/ssmw_regs.sv */
// Sequencer status, rail fault mask, lock, restart and memory window register bank
//
// Overview of operation
// - Status read clears all bits except the stored-log-present bit.
// - Failed host access, such as an invalid address, sets status bit 7.
// - Too many bytes for the addressed register fails the access and sets bit 7.
// - Bits 1:0 give fault cause: none, bad address, read error, write error.
// - Any rail problem sets the rail fault flag, status bit 6.
// - Bit 5 is set at reset when the stored log has entries; changes only at reset.
// - Corrupt firmware sets status bit 4 and the device goes idle.
// - Invalid configuration sets status bit 3 and reloads last good configuration.
// - Revision register shows major and minor numbers as two nibbles.
// - Sixteen-bit rail mask: high byte first register, low byte second; 8 or 16-bit reads.
// - Reading a rail mask byte clears the bits it returned.
// - Lock register locks memory; updates proceed only while unlocked.
// - Restart value 0x00: wait 50 us, then reset and re-sequence all rails.
// - Restart value 0xC0: shut rails and outputs down, then resume monitoring.
// - Window address from low and high bytes; one 16-bit write to low sets both.
// - Window data from low and high bytes; one 16-bit write to low sets both.
// - Data registers return the word at the window address, low byte first.
`timescale 1ns/1ps
`default_nettype none

module ssmw_regs
	import ssmw_pkg::*;
#(
	parameter logic [3:0] REV_MAJOR   = 4'h1,        // Arbitrary value
	parameter logic [3:0] REV_MINOR   = 4'h0,        // Arbitrary value
	parameter int         RESTART_WAIT = ssmw_pkg::RESTART_CYC
) (
	input  wire logic        clk_sys,            // System clock, 40 MHz
	input  wire logic        reset,              // Asynchronous reset, active high
	input  wire logic        xfer_start,         // Pulse: new transaction at xfer_ptr
	input  wire logic [7:0]  xfer_ptr,           // Register pointer from the host
	input  wire logic        wr_valid,           // Pulse: one byte written
	input  wire logic [7:0]  wr_byte,            // Byte written
	input  wire logic        rd_req,             // Pulse: one byte read
	output logic      [7:0]  rd_data,            // Read byte
	output logic             rd_valid,           // Pulse: rd_data valid
	input  wire logic [15:0] rail_fault_set,     // Pulses: rail reports a fault
	input  wire logic        firmware_fault_set, // Pulse: firmware memory corrupt
	input  wire logic        config_invalid_set, // Pulse: configuration invalid
	input  wire logic        stored_log_in,      // Level: stored error log not empty
	input  wire logic [15:0] window_rdata,       // Word at window address
	output logic      [15:0] window_addr,        // Memory window address
	output logic      [15:0] window_wdata,       // Memory window write data
	output logic             window_write,       // Pulse: write word at window address
	output logic             memory_unlocked,    // Level: updates allowed
	output logic             self_reset_req,     // Pulse: reset and re-sequence
	output logic             shutdown_req,       // Pulse: run shutdown sequence
	output logic             config_fallback,    // Pulse: load last good configuration
	output logic             device_idle         // Level: firmware corrupt, stay idle
);
	import ssmw_pkg::*;

	if (RESTART_WAIT < 1 || RESTART_WAIT >= (1 << RESTART_CNT_W)) begin : g_chk
		$error("RESTART_WAIT out of range");
	end

	////////////////////////////////////////////////////////////////////////////
	// Access decode

	logic [7:0]          ptr;
	logic [1:0]          xfer_cnt;
	logic [7:0]          status;
	logic [15:0]         rail_fault_mask;
	logic [7:0]          lock_reg;
	logic                init_done;
	logic                known;
	logic                rd_ok;
	logic                wr_ok;
	logic [1:0]          lim;
	logic [7:0]          next_ptr;
	logic [7:0]          rd_sel;
	logic                acc;
	logic                overrun;
	logic                fail;
	logic [1:0]          cause;
	logic                good_rd;
	logic                good_wr;
	ssmw_restart_state_t rs_state;
	logic [RESTART_CNT_W-1:0] rs_cnt;

	always_comb begin
		known   = 1'b1;
		rd_ok   = 1'b1;
		wr_ok   = 1'b0;
		lim     = LIM_SINGLE;
		next_ptr = ptr;
		rd_sel  = 8'h00;
		if (ptr >= REG_RAIL_FIRST && ptr <= REG_RAIL_LAST) begin
			lim      = LIM_FREE;
			next_ptr = (ptr == REG_RAIL_LAST) ? REG_RAIL_FIRST : ptr + 8'h01;
		end else if (ptr >= REG_ERRLOG_FIRST && ptr <= REG_ERRLOG_LAST) begin
			lim      = LIM_FREE;
			next_ptr = (ptr == REG_ERRLOG_LAST) ? REG_ERRLOG_FIRST : ptr + 8'h01;
		end else begin
			case (ptr)
				REG_DEVICE_STATUS: rd_sel = status;
				REG_REVISION_INFO: rd_sel = {REV_MAJOR, REV_MINOR};
				REG_RAIL_MASK_HI: begin
					lim      = LIM_PAIR;
					next_ptr = REG_RAIL_MASK_LO;
					rd_sel   = rail_fault_mask[15:8];
				end
				REG_RAIL_MASK_LO: begin
					lim      = LIM_PAIR;
					next_ptr = REG_RAIL_MASK_HI;
					rd_sel   = rail_fault_mask[7:0];
				end
				REG_MEM_LOCK: begin
					wr_ok  = 1'b1;
					rd_sel = lock_reg;
				end
				REG_RESTART_CMD: begin
					wr_ok = 1'b1;
					rd_ok = 1'b0;
				end
				REG_WIN_ADDR_LO: begin
					wr_ok    = 1'b1;
					lim      = LIM_PAIR;
					next_ptr = REG_WIN_ADDR_HI;
					rd_sel   = window_addr[7:0];
				end
				REG_WIN_ADDR_HI: begin
					wr_ok    = 1'b1;
					lim      = LIM_PAIR;
					next_ptr = REG_WIN_ADDR_LO;
					rd_sel   = window_addr[15:8];
				end
				REG_WIN_DATA_LO: begin
					wr_ok    = 1'b1;
					lim      = LIM_PAIR;
					next_ptr = REG_WIN_DATA_HI;
					rd_sel   = window_rdata[7:0];
				end
				REG_WIN_DATA_HI: begin
					wr_ok    = 1'b1;
					lim      = LIM_PAIR;
					next_ptr = REG_WIN_DATA_LO;
					rd_sel   = window_rdata[15:8];
				end
				default: begin
					known = 1'b0;
					rd_ok = 1'b0;
				end
			endcase
		end
	end

	// Reads win if the front end ever raises both strobes at once
	assign acc     = wr_valid | rd_req;
	assign overrun = (lim != LIM_FREE) && (xfer_cnt >= lim);

	always_comb begin
		fail  = 1'b0;
		cause = CAUSE_NONE;
		if (acc) begin
			if (!known) begin
				fail  = 1'b1;
				cause = CAUSE_BAD_ADDR;
			end else if (rd_req && (!rd_ok || overrun)) begin
				fail  = 1'b1;
				cause = CAUSE_RD_ERR;
			end else if (!rd_req && (!wr_ok || overrun)) begin
				fail  = 1'b1;
				cause = CAUSE_WR_ERR;
			end
		end
	end

	assign good_rd = rd_req && !fail;
	assign good_wr = wr_valid && !rd_req && !fail;

	////////////////////////////////////////////////////////////////////////////
	// Pointer and byte count

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ptr      <= 8'h00;
			xfer_cnt <= 2'h0;
		end else if (xfer_start) begin
			ptr      <= xfer_ptr;
			xfer_cnt <= 2'h0;
		end else if (acc) begin
			ptr <= next_ptr;
			if (xfer_cnt != 2'h3) begin
				xfer_cnt <= xfer_cnt + 2'h1;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rd_data  <= 8'h00;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= rd_req;
			if (rd_req) begin
				rd_data <= good_rd ? rd_sel : 8'h00;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Status byte

	// The log flag is caught only on the first clock after reset release
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			init_done <= 1'b0;
		end else if (!init_done) begin
			init_done <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			status[ST_BUS_FAULT]  <= 1'b0;
			status[ST_RAIL_FAULT] <= 1'b0;
			status[ST_FW_FAULT]   <= 1'b0;
			status[ST_CFG_INVAL]  <= 1'b0;
			status[ST_LOG_PRES]   <= 1'b0;
			status[2]             <= 1'b0;
			status[1:0]           <= CAUSE_NONE;
		end else begin
			// One writer for the whole byte; the log bit moves only here
			if (!init_done) begin
				status[ST_LOG_PRES] <= stored_log_in;
			end
			if (good_rd && ptr == REG_DEVICE_STATUS) begin
				status[ST_BUS_FAULT]  <= 1'b0;
				status[ST_RAIL_FAULT] <= 1'b0;
				status[ST_FW_FAULT]   <= 1'b0;
				status[ST_CFG_INVAL]  <= 1'b0;
				status[1:0]           <= CAUSE_NONE;
			end
			// Sets come after the clear so a same-cycle event survives
			if (fail) begin
				status[ST_BUS_FAULT] <= 1'b1;
				status[1:0]          <= cause;
			end
			if (|rail_fault_set) begin
				status[ST_RAIL_FAULT] <= 1'b1;
			end
			if (firmware_fault_set) begin
				status[ST_FW_FAULT] <= 1'b1;
			end
			if (config_invalid_set) begin
				status[ST_CFG_INVAL] <= 1'b1;
			end
		end
	end

	// Idle holds until reset even after the status bit is read away
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			device_idle     <= 1'b0;
			config_fallback <= 1'b0;
		end else begin
			config_fallback <= config_invalid_set;
			if (firmware_fault_set) begin
				device_idle <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Rail fault mask

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rail_fault_mask <= 16'h0000;
		end else begin
			if (good_rd && ptr == REG_RAIL_MASK_HI) begin
				rail_fault_mask[15:8] <= rail_fault_set[15:8];
			end else begin
				rail_fault_mask[15:8] <= rail_fault_mask[15:8] | rail_fault_set[15:8];
			end
			if (good_rd && ptr == REG_RAIL_MASK_LO) begin
				rail_fault_mask[7:0] <= rail_fault_set[7:0];
			end else begin
				rail_fault_mask[7:0] <= rail_fault_mask[7:0] | rail_fault_set[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Lock and memory window

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			lock_reg        <= LOCK_CLOSED;
			memory_unlocked <= 1'b0;
		end else if (good_wr && ptr == REG_MEM_LOCK) begin
			lock_reg        <= wr_byte;
			memory_unlocked <= (wr_byte == LOCK_OPEN);
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			window_addr  <= 16'h0000;
			window_wdata <= 16'h0000;
			window_write <= 1'b0;
		end else begin
			window_write <= 1'b0;
			if (good_wr) begin
				case (ptr)
					REG_WIN_ADDR_LO: window_addr[7:0]  <= wr_byte;
					REG_WIN_ADDR_HI: window_addr[15:8] <= wr_byte;
					REG_WIN_DATA_LO: window_wdata[7:0] <= wr_byte;
					REG_WIN_DATA_HI: begin
						window_wdata[15:8] <= wr_byte;
						// Word is committed on its high byte, and only when open
						window_write       <= memory_unlocked;
					end
					default: begin
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Restart and shutdown commands

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rs_state       <= SSMW_RS_IDLE;
			rs_cnt         <= '0;
			self_reset_req <= 1'b0;
			shutdown_req   <= 1'b0;
		end else begin
			self_reset_req <= 1'b0;
			shutdown_req   <= 1'b0;
			case (rs_state)
				SSMW_RS_IDLE: begin
					if (good_wr && ptr == REG_RESTART_CMD) begin
						if (wr_byte == CMD_RESTART) begin
							rs_state <= SSMW_RS_WAIT;
							rs_cnt   <= RESTART_CNT_W'(RESTART_WAIT - 1);
						end else if (wr_byte == CMD_SHUTDOWN) begin
							shutdown_req <= 1'b1;
						end
					end
				end
				SSMW_RS_WAIT: begin
					// Hold-off lets the acknowledge finish before reset
					if (rs_cnt == '0) begin
						self_reset_req <= 1'b1;
						rs_state       <= SSMW_RS_IDLE;
					end else begin
						rs_cnt <= rs_cnt - 1'b1;
					end
				end
				default: rs_state <= SSMW_RS_IDLE;
			endcase
		end
	end
endmodule : ssmw_regs

`default_nettype wire

/* File: verif/ssmw_props.sv */
// Checker: timing relations of the sequencer register bank ports
`timescale 1ns/1ps
`default_nettype none
module ssmw_props
	import ssmw_pkg::*;
#(
	parameter int RESTART_WAIT = 4
) (
	input wire logic        clk_sys,            // Clock
	input wire logic        reset,              // Reset
	input wire logic        xfer_start,         // New transaction
	input wire logic [7:0]  xfer_ptr,           // Pointer
	input wire logic        wr_valid,           // Byte write
	input wire logic [7:0]  wr_byte,            // Write byte
	input wire logic        rd_req,             // Byte read
	input wire logic [7:0]  rd_data,            // Read byte
	input wire logic        rd_valid,           // Read byte valid
	input wire logic [15:0] window_rdata,       // Memory word
	input wire logic [15:0] window_addr,        // Window address
	input wire logic [15:0] window_wdata,       // Window data
	input wire logic        window_write,       // Memory write
	input wire logic        memory_unlocked,    // Lock state
	input wire logic        self_reset_req,     // Restart
	input wire logic        shutdown_req,       // Shutdown
	input wire logic        config_invalid_set, // Config fault
	input wire logic        config_fallback,    // Config reload
	input wire logic        firmware_fault_set, // Firmware fault
	input wire logic        device_idle         // Idle
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	logic [7:0] ptr;
	logic [7:0] rcnt;
	logic       acc;
	assign acc = (wr_valid | rd_req) & ~xfer_start;
	////////////////////////////////////////////////////////////////
	// Tracks only the paired registers; other pointers stay put
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			ptr <= 8'h00;
		else if (xfer_start)
			ptr <= xfer_ptr;
		else if (acc && (ptr[7:1] == 7'h14 || ptr[7:1] == 7'h18 || ptr[7:1] == 7'h19))
			ptr <= ptr ^ 8'h01;
	end
	// Cycles since the restart command, saturating
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			rcnt <= 8'h00;
		else if (acc && wr_valid && ptr == REG_RESTART_CMD && wr_byte == CMD_RESTART)
			rcnt <= 8'h01;
		else if (rcnt != 8'h00 && rcnt != 8'hFF)
			rcnt <= rcnt + 8'h01;
	end
	////////////////////////////////////////////////////////////////
	property p_fb; config_invalid_set |=> config_fallback; endproperty
	a_fb: assert property (p_fb) else $error("no config reload");
	property p_idle; firmware_fault_set |=> device_idle [*3]; endproperty
	a_idle: assert property (p_idle) else $error("not idle");
	property p_wwr;
		window_write |-> memory_unlocked && $past(wr_valid) && window_wdata[15:8] == $past(wr_byte);
	endproperty
	a_wwr: assert property (p_wwr) else $error("bad memory write");
	property p_shut;
		acc && wr_valid && ptr == REG_RESTART_CMD && wr_byte == CMD_SHUTDOWN |=> shutdown_req;
	endproperty
	a_shut: assert property (p_shut) else $error("no shutdown");
	property p_rst; (int'(rcnt) == RESTART_WAIT + 1) == self_reset_req; endproperty
	a_rst: assert property (p_rst) else $error("restart timing");
	property p_addr;
		acc && wr_valid && ptr == REG_WIN_ADDR_HI |=> window_addr[15:8] == $past(wr_byte);
	endproperty
	a_addr: assert property (p_addr) else $error("address high byte");
	property p_rdat;
		acc && rd_req && ptr == REG_WIN_DATA_LO |=> rd_data == $past(window_rdata[7:0]);
	endproperty
	a_rdat: assert property (p_rdat) else $error("window low byte");
	property p_lock;
		acc && wr_valid && ptr == REG_MEM_LOCK |=> memory_unlocked == ($past(wr_byte) == LOCK_OPEN);
	endproperty
	a_lock: assert property (p_lock) else $error("lock state");
	property p_rdv; rd_valid == $past(rd_req); endproperty
	a_rdv: assert property (p_rdv) else $error("read valid timing");
	c_win: cover property (window_write);
	c_rst: cover property (self_reset_req);
	c_shut: cover property (shutdown_req);
endmodule : ssmw_props
`default_nettype wire

/* File: verif/ssmw_host.sv */
// Host link model: transaction start, byte writes and byte reads
`timescale 1ns/1ps
`default_nettype none
module ssmw_host (
	input  wire logic       clk_sys,    // Clock
	output logic            xfer_start, // New transaction
	output logic [7:0]      xfer_ptr,   // Pointer
	output logic            wr_valid,   // Byte write
	output logic [7:0]      wr_byte,    // Write byte
	output logic            rd_req,     // Byte read
	input  wire logic [7:0] rd_data     // Read byte
);
	initial begin
		xfer_start = 1'b0;
		xfer_ptr = 8'h00;
		wr_valid = 1'b0;
		wr_byte = 8'h00;
		rd_req = 1'b0;
	end
	// One strobe a cycle; an idle data byte flips so a stale value never looks valid
	task automatic step(input logic s, input logic w, input logic r, input logic [7:0] v);
		@(posedge clk_sys);
		#2;
		xfer_start = s;
		wr_valid = w;
		rd_req = r;
		if (s)
			xfer_ptr = v;
		wr_byte = w ? v : ~wr_byte;
	endtask : step
	task automatic go(input logic [7:0] p);
		step(1'b1, 1'b0, 1'b0, p);
	endtask : go
	task automatic wr(input logic [7:0] b);
		step(1'b0, 1'b1, 1'b0, b);
	endtask : wr
	task automatic rd(output logic [7:0] b);
		step(1'b0, 1'b0, 1'b1, 8'h00);
		step(1'b0, 1'b0, 1'b0, 8'h00);
		b = rd_data;
	endtask : rd
	task automatic put(input logic [7:0] p, input logic [7:0] b);
		go(p);
		wr(b);
		step(1'b0, 1'b0, 1'b0, 8'h00);
	endtask : put
	task automatic get(input logic [7:0] p, output logic [7:0] b);
		go(p);
		rd(b);
	endtask : get
endmodule : ssmw_host
`default_nettype wire

/* File: verif/sequencer_status_and_memory_window_regs_test.sv */
// Testbench: sequencer status, rail mask, lock, restart and window registers
`timescale 1ns/1ps
`default_nettype none
module sequencer_status_and_memory_window_regs_test;
	import ssmw_pkg::*;
	localparam int WAIT_CYC = 4;
	logic clk_sys = 1'b0, reset = 1'b1, xfer_start, wr_valid, rd_req, rd_valid;
	logic firmware_fault_set = 1'b0, config_invalid_set = 1'b0, stored_log_in = 1'b0;
	logic window_write, memory_unlocked, self_reset_req, shutdown_req;
	logic config_fallback, device_idle;
	logic [7:0] xfer_ptr, wr_byte, rd_data, b;
	logic [15:0] rail_fault_set = 16'h0000, window_rdata, window_addr, window_wdata;
	int err_total = 0, num_checks = 0, n_ww = 0, n;
	always #12.5 clk_sys = ~clk_sys;
	// Memory model: word depends on the address so each address reads distinctly
	assign window_rdata = window_addr ^ 16'h5A3C;
	always @(posedge clk_sys) if (window_write === 1'b1) n_ww++;
	ssmw_regs #(.RESTART_WAIT(WAIT_CYC)) dut (.*);
	ssmw_host u_host (.*);
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask : chk
	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim
	task automatic do_reset(input logic lg);
		stored_log_in = lg;
		reset = 1'b1;
		repeat (4) @(posedge clk_sys);
		#2;
		reset = 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask : do_reset
	task automatic pulse_in(input logic fw, input logic cf, input logic [15:0] rl);
		@(posedge clk_sys);
		#2;
		{firmware_fault_set, config_invalid_set, rail_fault_set} = {fw, cf, rl};
		@(posedge clk_sys);
		#2;
		{firmware_fault_set, config_invalid_set, rail_fault_set} = 18'h00000;
	endtask : pulse_in
	////////////////////////////////////////////////////////////////
	task automatic t_status;
		u_host.get(REG_REVISION_INFO, b); chk("revision", 8'h10, b);
		u_host.get(8'h40, b); chk("bad pointer data", 8'h00, b);
		u_host.get(REG_DEVICE_STATUS, b); chk("status bad addr", 8'hA1, b);
		u_host.get(REG_RESTART_CMD, b); chk("write-only data", 8'h00, b);
		u_host.get(REG_DEVICE_STATUS, b); chk("status read err", 8'hA2, b);
		u_host.put(REG_REVISION_INFO, 8'h55);
		u_host.get(REG_DEVICE_STATUS, b); chk("status write err", 8'hA3, b);
		u_host.get(REG_DEVICE_STATUS, b); chk("status cleared", 8'h20, b);
		$display("done status");
	endtask : t_status
	task automatic t_rail;
		pulse_in(1'b0, 1'b0, 16'h8001);
		u_host.get(REG_DEVICE_STATUS, b); chk("rail flag", 8'h60, b);
		u_host.go(REG_RAIL_MASK_HI);
		u_host.rd(b); chk("mask high", 8'h80, b);
		u_host.rd(b); chk("mask low", 8'h01, b);
		u_host.rd(b); chk("third byte", 8'h00, b);
		u_host.get(REG_DEVICE_STATUS, b); chk("count fault", 8'hA2, b);
		u_host.go(REG_RAIL_MASK_HI);
		u_host.rd(b); chk("mask high clear", 8'h00, b);
		u_host.rd(b); chk("mask low clear", 8'h00, b);
		$display("done rail");
	endtask : t_rail
	task automatic t_win;
		u_host.put(REG_MEM_LOCK, LOCK_OPEN);
		chk("unlocked", 1'b1, memory_unlocked);
		u_host.go(REG_WIN_ADDR_LO);
		u_host.wr(8'h34);
		u_host.wr(8'h12);
		u_host.step(1'b0, 1'b0, 1'b0, 8'h00);
		chk("window addr", 16'h1234, window_addr);
		u_host.go(REG_WIN_DATA_LO);
		u_host.wr(8'hEF);
		u_host.wr(8'hBE);
		u_host.go(REG_WIN_DATA_LO);
		chk("window data", 16'hBEEF, window_wdata);
		u_host.rd(b); chk("read low", 8'h08, b);
		u_host.rd(b); chk("read high", 8'h48, b);
		u_host.put(REG_MEM_LOCK, LOCK_CLOSED);
		chk("locked", 1'b0, memory_unlocked);
		u_host.go(REG_WIN_DATA_LO);
		u_host.wr(8'h11);
		u_host.put(REG_WIN_DATA_HI, 8'h22);
		u_host.step(1'b0, 1'b0, 1'b0, 8'h00);
		chk("memory writes", 16'd1, n_ww[15:0]);
		$display("done window");
	endtask : t_win
	task automatic t_cmd;
		u_host.put(REG_RESTART_CMD, CMD_SHUTDOWN);
		chk("shutdown", 1'b1, shutdown_req);
		u_host.put(REG_RESTART_CMD, CMD_RESTART);
		n = 0;
		while (self_reset_req !== 1'b1 && n < 50) begin
			@(posedge clk_sys);
			#2;
			n++;
		end
		chk("restart delay", WAIT_CYC, n[15:0]);
		$display("done restart");
	endtask : t_cmd
	task automatic t_events;
		pulse_in(1'b1, 1'b1, 16'h0000);
		chk("idle", 1'b1, device_idle);
		u_host.go(REG_DEVICE_STATUS);
		fork
			u_host.step(1'b0, 1'b0, 1'b1, 8'h00);
			begin
				@(posedge clk_sys);
				#2;
				rail_fault_set = 16'h0100;
			end
		join
		u_host.step(1'b0, 1'b0, 1'b0, 8'h00);
		rail_fault_set = 16'h0000;
		chk("fault flags", 8'h38, rd_data);
		u_host.get(REG_DEVICE_STATUS, b); chk("event kept", 8'h60, b);
		u_host.get(REG_DEVICE_STATUS, b); chk("log bit kept", 8'h20, b);
		$display("done events");
	endtask : t_events
	task automatic t_reset;
		do_reset(1'b0);
		u_host.get(REG_DEVICE_STATUS, b); chk("log bit gone", 8'h00, b);
		$display("done reset");
	endtask : t_reset
	////////////////////////////////////////////////////////////////
	initial begin
		#2ms;
		err_total++;
		end_sim();
	end
	initial begin
		do_reset(1'b1);
		t_status();
		t_rail();
		t_win();
		t_cmd();
		t_events();
		t_reset();
		end_sim();
	end
endmodule : sequencer_status_and_memory_window_regs_test
bind ssmw_regs ssmw_props #(.RESTART_WAIT(RESTART_WAIT)) u_props (.*);
`default_nettype wire
